// [rtl/rms_consts.svh]
// constants of the radio module mode and status block
`ifndef RMS_CONSTS_SVH
`define RMS_CONSTS_SVH

`define RMS_CLK_MHZ 125
`define RMS_SWITCH_US 1000
`define RMS_SETTLE_US 2000
`define RMS_SELFCHECK_US 10000
`define RMS_PARLOAD_US 5000
`define RMS_GAP_US 100
`define RMS_SWITCH_CYC (`RMS_SWITCH_US * `RMS_CLK_MHZ)
`define RMS_SETTLE_CYC (`RMS_SETTLE_US * `RMS_CLK_MHZ)
`define RMS_SELFCHECK_CYC (`RMS_SELFCHECK_US * `RMS_CLK_MHZ)
`define RMS_PARLOAD_CYC (`RMS_PARLOAD_US * `RMS_CLK_MHZ)
`define RMS_GAP_CYC (`RMS_GAP_US * `RMS_CLK_MHZ)

`define RMS_TXBUF_DEPTH 400

`define RMS_REG_ADDR 12'h000
`define RMS_REG_STATUS 12'h004
`define RMS_ADDR_RESET 16'h0000
`define RMS_ADDR_ONES 16'hFFFF
`define RMS_ADDR_ZEROS 16'h0000

`define RMS_ST_AUX 0
`define RMS_ST_MODE 1
`define RMS_ST_PINS 3
`define RMS_ST_ACTIVE 5
`define RMS_ST_UBUSY 6
`define RMS_ST_COUNT 8

`endif

// [rtl/rms_pkg.sv]
// types of the radio module mode and status block
package rms_pkg;
    typedef logic [1:0] rms_mode_t;
    typedef enum logic [1:0] {ST_SELFCHECK, ST_LOAD, ST_RUN} rms_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} rms_tx_t;
    localparam rms_mode_t MODE_NORMAL = 2'h0;
    localparam rms_mode_t MODE_WOR_TX = 2'h1;
    localparam rms_mode_t MODE_WOR_RX = 2'h2;
    localparam rms_mode_t MODE_SLEEP = 2'h3;
endpackage

// [rtl/rms_status.sv]
// mode selection, status output, transmit buffer and address filter
// Summary of operation
// [R1] own address all-ones or all-zeros: outgoing data marked broadcast
// [R2] own address all-ones or all-zeros: accept received data of any address
// [R3] status low from power-up through self-check and parameter load
// [R4] status rises after self-check; then run the mode the pins select
// [R5] host waits for the first status rising edge before using the module
// [R6] status is the AND of all not-busy conditions
// [R7] 400-byte transmit buffer; status low while it holds data
// [R8] status stays low during data-end timeout and during radio sending
// [R9] while status high, host may send up to 400 bytes without overflow
// [R10] status rises once the last byte is handed to the radio transceiver
// [R11] pins ignored while status low; pending change done 1ms after rise
// [R12] after a busy period the new mode runs after 2ms of status high
// [R13] status high and staying high: pin change applied immediately
// [R14] leaving mode 3 reloads parameters with status held low
// [R15] parameter load happens only at power-on or on leaving sleep
// [R16] both pins low: mode 0, transparent both ways
// [R17] low pin high only: mode 1, wake-over-air preambles
// [R18] high pin high only: mode 2, radio send off, wake listening on
// [R19] both pins high: mode 3 deep sleep, configuration allowed
// [R20] status low while received data goes out on the UART
// [R21] host changes pins only 2ms after it sees status high
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "rms_consts.svh"

module rms_status
    import rms_pkg::*;
#(
    parameter int unsigned SWITCH_CYC = `RMS_SWITCH_CYC,
    parameter int unsigned SETTLE_CYC = `RMS_SETTLE_CYC,
    parameter int unsigned SELFCHECK_CYC = `RMS_SELFCHECK_CYC,
    parameter int unsigned PARLOAD_CYC = `RMS_PARLOAD_CYC,
    parameter int unsigned GAP_CYC = `RMS_GAP_CYC,
    parameter int unsigned DEPTH = `RMS_TXBUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic modeSelLow,
    input wire logic modeSelHigh,
    output logic auxOut,
    input wire logic hostByteValid,
    input wire logic [7:0] hostByte,
    output logic hostByteReady,
    output logic radioTxValid,
    output logic [7:0] radioTxByte,
    output logic [15:0] radioTxDest,
    output logic radioTxBroadcast,
    input wire logic radioTxReady,
    input wire logic radioRxValid,
    input wire logic [7:0] radioRxByte,
    input wire logic [15:0] radioRxDest,
    input wire logic radioRxLast,
    output logic radioRxReady,
    output logic uartTxValid,
    output logic [7:0] uartTxByte,
    input wire logic uartTxReady,
    output logic [1:0] modeOut,
    output logic modeActive,
    output logic radioTxEnable,
    output logic radioRxEnable,
    output logic worPreamble,
    output logic worListen,
    output logic configEnable
);

    localparam int CW = 24;
    localparam int PW = $clog2(DEPTH);

    function automatic logic isWild(input logic [15:0] a);
        return (a == `RMS_ADDR_ONES) || (a == `RMS_ADDR_ZEROS);
    endfunction

    function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // pin synchronisers
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta <= 2'h0;
            pinSync <= 2'h0;
        end else begin
            pinMeta <= {modeSelHigh, modeSelLow};
            pinSync <= pinMeta;
        end
    end
    rms_mode_t pinMode;
    assign pinMode = pinSync;

    // power-up and parameter load sequence
    rms_state_t state;
    rms_mode_t curMode;
    rms_mode_t next_curMode;
    logic leaveSleep;
    logic [CW-1:0] seqCnt;
    assign leaveSleep = (curMode == MODE_SLEEP) && (next_curMode != MODE_SLEEP);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_SELFCHECK;
            seqCnt <= '0;
        end else begin
            case (state)
                ST_SELFCHECK: begin
                    if (seqCnt == CW'(SELFCHECK_CYC - 1)) begin
                        state <= ST_LOAD; // R3
                        seqCnt <= '0;
                    end else begin
                        seqCnt <= seqCnt + CW'(1);
                    end
                end
                ST_LOAD: begin
                    if (seqCnt == CW'(PARLOAD_CYC - 1)) begin
                        state <= ST_RUN; // R4
                        seqCnt <= '0;
                    end else begin
                        seqCnt <= seqCnt + CW'(1);
                    end
                end
                ST_RUN: begin
                    if (leaveSleep) begin
                        state <= ST_LOAD; // R14 R15
                        seqCnt <= '0;
                    end
                end
                default: begin
                    state <= ST_SELFCHECK;
                    seqCnt <= '0;
                end
            endcase
        end
    end

    // software registers
    logic [15:0] ownAddr;
    logic uartBusy;
    logic [PW:0] count;
    logic apbAccess;
    logic addrHit;
    logic statHit;
    assign apbAccess = psel && penable && !pready;
    assign addrHit = paddr == `RMS_REG_ADDR;
    assign statHit = paddr == `RMS_REG_STATUS;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ownAddr <= `RMS_ADDR_RESET;
        end else if (psel && penable && pready && pwrite && addrHit) begin
            // write lands on the completing edge
            ownAddr <= pwdata[15:0];
        end
    end

    logic [31:0] statusWord;
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[`RMS_ST_AUX] = auxOut;
        statusWord[`RMS_ST_MODE +: 2] = curMode;
        statusWord[`RMS_ST_PINS +: 2] = pinMode;
        statusWord[`RMS_ST_ACTIVE] = modeActive;
        statusWord[`RMS_ST_UBUSY] = uartBusy;
        statusWord[`RMS_ST_COUNT +: PW + 1] = count;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbAccess;
            pslverr <= apbAccess && !addrHit && !statHit;
            if (apbAccess && !pwrite && addrHit) begin
                prdata <= {16'h0000, ownAddr};
            end else if (apbAccess && !pwrite && statHit) begin
                prdata <= statusWord;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // mode selection gated by the status output
    logic [CW-1:0] highCnt;
    logic afterBusy;
    logic changed;
    always_comb begin
        next_curMode = curMode;
        if (state == ST_RUN && auxOut) begin
            if (!afterBusy) begin
                next_curMode = pinMode; // R13
            end else if (highCnt == CW'(SWITCH_CYC - 1)) begin
                next_curMode = pinMode; // R11
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            curMode <= MODE_NORMAL;
            highCnt <= '0;
            afterBusy <= 1'b1;
            changed <= 1'b0;
            modeActive <= 1'b0;
        end else begin
            curMode <= next_curMode;
            if (!auxOut) begin
                highCnt <= '0;
                afterBusy <= 1'b1; // R11
            end else if (highCnt != CW'(SETTLE_CYC)) begin
                highCnt <= highCnt + CW'(1);
            end
            if (auxOut && highCnt == CW'(SWITCH_CYC - 1)) begin
                afterBusy <= 1'b0;
                // keep a change that is still settling
                changed <= changed || next_curMode != curMode;
            end
            if (afterBusy && changed) begin
                modeActive <= 1'b0;
            end
            if (!afterBusy && changed && highCnt == CW'(SETTLE_CYC)) begin
                modeActive <= 1'b1; // R12 R21
                changed <= 1'b0;
            end else if (!afterBusy && !changed && state == ST_RUN) begin
                modeActive <= 1'b1;
            end
            if (auxOut && afterBusy && highCnt == CW'(SWITCH_CYC - 1)
                && next_curMode != curMode) begin
                modeActive <= 1'b0;
            end
        end
    end

    // mode decode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modeOut <= MODE_NORMAL;
            radioTxEnable <= 1'b0;
            radioRxEnable <= 1'b0;
            worPreamble <= 1'b0;
            worListen <= 1'b0;
            configEnable <= 1'b0;
        end else begin
            modeOut <= curMode;
            radioTxEnable <= modeActive && curMode[1] == 1'b0; // R16 R17
            radioRxEnable <= modeActive && curMode != MODE_SLEEP; // R16
            worPreamble <= modeActive && curMode == MODE_WOR_TX; // R17
            worListen <= modeActive && curMode == MODE_WOR_RX; // R18
            configEnable <= curMode == MODE_SLEEP; // R19
        end
    end

    // transmit buffer
    logic [7:0] txMem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic push;
    logic pop;
    logic [PW:0] next_count;
    rms_tx_t txState;
    logic [CW-1:0] gapCnt;
    logic txOpen;
    assign txOpen = state == ST_RUN && curMode[1] == 1'b0;
    assign push = hostByteValid && hostByteReady;
    assign pop = txState == TX_SEND && count != '0
        && (!radioTxValid || radioTxReady);
    assign next_count = count + (PW + 1)'(push) - (PW + 1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            txMem[wrPtr] <= hostByte; // R7
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            hostByteReady <= 1'b0;
        end else begin
            if (push) begin
                wrPtr <= nextPtr(wrPtr);
            end
            if (pop) begin
                rdPtr <= nextPtr(rdPtr);
            end
            count <= next_count;
            hostByteReady <= txOpen && next_count < (PW + 1)'(DEPTH); // R9
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txState <= TX_IDLE;
            gapCnt <= '0;
        end else begin
            case (txState)
                TX_IDLE: begin
                    gapCnt <= '0;
                    if (push) begin
                        txState <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (push) begin
                        gapCnt <= '0;
                    end else if (gapCnt == CW'(GAP_CYC - 1)
                        || count == (PW + 1)'(DEPTH)) begin
                        txState <= TX_SEND; // R8
                    end else begin
                        gapCnt <= gapCnt + CW'(1);
                    end
                end
                TX_SEND: begin
                    if (count == '0 && !radioTxValid) begin
                        txState <= push ? TX_WAIT : TX_IDLE;
                    end
                end
                default: begin
                    txState <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            radioTxValid <= 1'b0;
            radioTxByte <= 8'h00;
            radioTxDest <= `RMS_ADDR_RESET;
            radioTxBroadcast <= 1'b0;
        end else begin
            radioTxDest <= ownAddr;
            radioTxBroadcast <= isWild(ownAddr); // R1
            if (pop) begin
                radioTxValid <= 1'b1;
                radioTxByte <= txMem[rdPtr];
            end else if (radioTxReady) begin
                radioTxValid <= 1'b0; // R10
            end
        end
    end

    // received radio data to the UART
    logic rxTake;
    logic rxMatch;
    logic lastPending;
    assign rxTake = radioRxValid && radioRxReady;
    assign rxMatch = isWild(ownAddr) || radioRxDest == ownAddr; // R2

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            radioRxReady <= 1'b0;
            uartTxValid <= 1'b0;
            uartTxByte <= 8'h00;
            uartBusy <= 1'b0;
            lastPending <= 1'b0;
        end else begin
            radioRxReady <= state == ST_RUN && curMode != MODE_SLEEP
                && !rxTake && (!uartTxValid || uartTxReady);
            if (rxTake && rxMatch) begin
                uartTxValid <= 1'b1;
                uartTxByte <= radioRxByte;
                uartBusy <= 1'b1; // R20
                lastPending <= radioRxLast;
            end else if (uartTxValid && uartTxReady) begin
                uartTxValid <= 1'b0;
                if (lastPending) begin
                    uartBusy <= 1'b0;
                    lastPending <= 1'b0;
                end
            end
        end
    end

    // status output: high only when nothing is busy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            auxOut <= 1'b0; // R3
        end else begin
            auxOut <= state == ST_RUN && count == '0 && !radioTxValid
                && !uartBusy; // R6 R7 R10
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_buffer_holds_low: assert property (
        count != '0 |=> !auxOut) // R7
        else $error("status high while transmit buffer holds data");
    a_startup_low: assert property (
        state != ST_RUN |=> !auxOut) // R3
        else $error("status high before run state");
    a_rise_in_run: assert property (
        $rose(auxOut) |-> $past(state) == ST_RUN) // R4
        else $error("status rose outside run state");
    a_uart_busy_low: assert property (
        $rose(uartTxValid) |=> !auxOut [*2]) // R20
        else $error("status high while UART sends received data");
    a_mode_frozen_busy: assert property (
        !auxOut |=> $stable(curMode)) // R11
        else $error("mode changed while status low");
    a_mode_immediate: assert property (
        auxOut && !afterBusy && state == ST_RUN && pinMode != curMode
        |=> curMode == $past(pinMode)) // R13
        else $error("idle mode change not applied at once");
    a_sleep_exit_load: assert property (
        $fell(curMode == MODE_SLEEP) |-> state == ST_LOAD ##1 !auxOut) // R14
        else $error("leaving sleep did not reload parameters");
    a_load_cause: assert property (
        $rose(state == ST_LOAD) |-> $past(state) == ST_SELFCHECK
        || $past(curMode) == MODE_SLEEP) // R15
        else $error("parameter load without power-on or sleep exit");
    a_monitor_accept: assert property (
        rxTake && isWild(ownAddr) |=> uartTxValid) // R2
        else $error("monitor address dropped received data");
    a_idle_rises: assert property (
        state == ST_RUN && count == '0 && !radioTxValid && !uartBusy
        |=> auxOut) // R10
        else $error("status not high once all data handed over");
    a_settle_active: assert property (
        $fell(modeActive) && state == ST_RUN |-> auxOut
        ##1 !modeActive [*8]) // R12
        else $error("new mode active before settle time");

    c_buffer_drain: cover property (pop ##[1:20] $rose(auxOut));
    c_sleep_exit: cover property ($fell(curMode == MODE_SLEEP));
    c_monitor_rx: cover property (rxTake && isWild(ownAddr));
    c_busy_switch: cover property ($rose(modeActive) && $past(changed));

endmodule

// [tb/rms_radio_model.sv]
// radio transceiver side model: takes bytes, can stall
`timescale 1ns/1ns

module rms_radio_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic radioTxValid,
    input wire logic [7:0] radioTxByte,
    input wire logic [15:0] radioTxDest,
    input wire logic radioTxBroadcast,
    output logic radioTxReady,
    output logic [15:0] takenCount,
    output logic [7:0] lastByte,
    output logic [15:0] lastDest,
    output logic lastBcast
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            radioTxReady <= 1'b0;
            takenCount <= 16'h0000;
            lastByte <= 8'h00;
            lastDest <= 16'h0000;
            lastBcast <= 1'b0;
        end else begin
            // one-cycle ready, never while stalled
            radioTxReady <= radioTxValid && !radioTxReady && !stall;
            if (radioTxValid && radioTxReady) begin
                takenCount <= takenCount + 16'h0001;
                lastByte <= radioTxByte;
                lastDest <= radioTxDest;
                lastBcast <= radioTxBroadcast;
            end
        end
    end
endmodule

// [tb/tb_top.sv]
// self-checking bench of the mode and status block
`timescale 1ns/1ns

module tb_top;
    localparam int SW = 20;
    localparam int ST = 40;
    localparam int SC = 30;
    localparam int PL = 25;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, auxOut, hostByteReady, radioTxValid;
    logic radioTxBroadcast, radioTxReady, radioRxReady, uartTxValid;
    logic modeActive, radioTxEnable, radioRxEnable;
    logic worPreamble, worListen, configEnable, lastBcast;
    logic [7:0] radioTxByte, uartTxByte, lastByte;
    logic [15:0] radioTxDest, takenCount, lastDest;
    logic [1:0] modeOut;
    logic modeSelLow = 1'b0;
    logic modeSelHigh = 1'b0;
    logic hostByteValid = 1'b0;
    logic [7:0] hostByte = 8'h00;
    logic radioRxValid = 1'b0;
    logic [7:0] radioRxByte = 8'h00;
    logic [15:0] radioRxDest = 16'h0000;
    logic radioRxLast = 1'b0;
    logic uartTxReady = 1'b0;
    logic stall = 1'b0;
    logic [6:0] decode;
    logic [31:0] r;
    logic e, ok;
    int n;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    // pins {high,low}, then mode, tx, rx, wor, listen, config
    logic [8:0] modeRows [4] = '{9'h018, 9'h0BC, 9'h14A, 9'h1E1};
    // own address, destination, accepted, wildcard
    logic [33:0] rxRows [4] = '{{16'h1234, 16'h5555, 2'b00},
        {16'h1234, 16'h1234, 2'b10}, {16'hFFFF, 16'h5555, 2'b11},
        {16'h0000, 16'h7777, 2'b11}};

    assign decode = {modeOut, radioTxEnable, radioRxEnable, worPreamble,
        worListen, configEnable};

    always #4 clk = ~clk;

    rms_status #(.SWITCH_CYC(SW), .SETTLE_CYC(ST), .SELFCHECK_CYC(SC),
        .PARLOAD_CYC(PL), .GAP_CYC(10), .DEPTH(400)) dut (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modeSelLow(modeSelLow), .modeSelHigh(modeSelHigh),
        .auxOut(auxOut), .hostByteValid(hostByteValid),
        .hostByte(hostByte), .hostByteReady(hostByteReady),
        .radioTxValid(radioTxValid), .radioTxByte(radioTxByte),
        .radioTxDest(radioTxDest), .radioTxBroadcast(radioTxBroadcast),
        .radioTxReady(radioTxReady), .radioRxValid(radioRxValid),
        .radioRxByte(radioRxByte), .radioRxDest(radioRxDest),
        .radioRxLast(radioRxLast), .radioRxReady(radioRxReady),
        .uartTxValid(uartTxValid), .uartTxByte(uartTxByte),
        .uartTxReady(uartTxReady), .modeOut(modeOut),
        .modeActive(modeActive), .radioTxEnable(radioTxEnable),
        .radioRxEnable(radioRxEnable), .worPreamble(worPreamble),
        .worListen(worListen), .configEnable(configEnable));

    rms_radio_model radio (
        .clk(clk), .rst(rst), .stall(stall),
        .radioTxValid(radioTxValid), .radioTxByte(radioTxByte),
        .radioTxDest(radioTxDest), .radioTxBroadcast(radioTxBroadcast),
        .radioTxReady(radioTxReady), .takenCount(takenCount),
        .lastByte(lastByte), .lastDest(lastDest), .lastBcast(lastBcast));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task push(input logic [7:0] b);
        int k;
        hostByte <= b;
        hostByteValid <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hostByteReady !== 1'b1 && k < 30);
        ok = hostByteReady === 1'b1;
    endtask

    task waitAux(input logic v, input int lim);
        int k;
        k = 0;
        while (auxOut !== v && k < lim) begin
            @(posedge clk);
            k++;
        end
        chk(auxOut, v);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            $display("BAD t=%0t timeout", $time);
            summarize();
        end
    end

    initial begin
        cyc(1);
        chk(auxOut, 1'b0);
        cyc(2);
        rst <= 1'b0;
        cyc(SC - 2);
        chk(auxOut, 1'b0);
        waitAux(1'b1, PL + 20);
        $display("reset test done");
        cyc(ST + 10);
        for (int i = 0; i < 4; i++) begin
            modeSelHigh <= modeRows[i][8];
            modeSelLow <= modeRows[i][7];
            cyc(5);
            chk(modeOut, modeRows[i][6:5]);
            cyc(ST + 10);
            chk(decode, modeRows[i][6:0]);
            chk(auxOut, 1'b1);
        end
        modeSelHigh <= 1'b0;
        modeSelLow <= 1'b0;
        cyc(7);
        chk(auxOut, 1'b0);
        cyc(PL - 10);
        chk(auxOut, 1'b0);
        waitAux(1'b1, 30);
        cyc(SW + ST + 10);
        chk(decode, 7'h18);
        apb(1'b0, 12'h004, 32'h0);
        chk(r[6:0], 7'h21);
        apb(1'b1, 12'h008, 32'hFFFF);
        chk(e, 1'b1);
        chk(r, 32'h0);
        $display("mode test done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, {16'h0, rxRows[i][33:18]});
            apb(1'b0, 12'h000, 32'h0);
            chk(r[15:0], rxRows[i][33:18]);
            chk(radioTxBroadcast, rxRows[i][0]);
            radioRxValid <= 1'b1;
            radioRxByte <= 8'hA5;
            radioRxDest <= rxRows[i][17:2];
            radioRxLast <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (radioRxReady !== 1'b1 && n < 30);
            radioRxValid <= 1'b0;
            radioRxByte <= 8'h5A;
            radioRxDest <= ~rxRows[i][17:2];
            cyc(3);
            chk(uartTxValid, rxRows[i][1]);
            chk(auxOut, !rxRows[i][1]);
            if (rxRows[i][1]) begin
                chk(uartTxByte, 8'hA5);
                uartTxReady <= 1'b1;
                cyc(1);
                uartTxReady <= 1'b0;
                waitAux(1'b1, 20);
            end
        end
        $display("receive test done");
        push(8'h11);
        push(8'h22);
        push(8'h33);
        hostByteValid <= 1'b0;
        cyc(8);
        chk(auxOut, 1'b0);
        waitAux(1'b1, 60);
        chk(takenCount, 16'd3);
        chk(lastByte, 8'h33);
        chk({lastBcast, lastDest}, 17'h10000);
        $display("transmit test done");
        stall <= 1'b1;
        n = 0;
        ok = 1'b1;
        while (ok) begin
            push(n[7:0]);
            if (ok)
                n++;
        end
        hostByteValid <= 1'b0;
        // one more byte waits in the radio output stage
        chk(n, 400 + 1);
        modeSelLow <= 1'b1;
        cyc(SW + 10);
        chk(modeOut, 2'h0);
        chk(auxOut, 1'b0);
        stall <= 1'b0;
        waitAux(1'b1, 1500);
        chk(modeOut, 2'h0);
        chk(takenCount, 16'h0194);
        chk(lastByte, 8'h90);
        cyc(SW + 4);
        chk(modeOut, 2'h1);
        chk(modeActive, 1'b0);
        cyc(ST - SW + 2);
        chk(modeActive, 1'b1);
        $display("buffer test done");
        summarize();
    end
endmodule
